// file: ccr_config_bank.sv
// Charger configuration register bank with watchdog and battery-FET control
`timescale 1ns/100ps
// How it works
// - Boost current limit bit: 0 gives 0.5 A, 1 gives 1.2 A, default 1.
// - Pass FET full-on 0: high resistance when input limit at most 700mA.
// - Fast charge current is code times 60mA, saturates at 3000mA, default 100010.
// - Precharge current 60mA plus code times 60mA, capped at 780mA.
// - Termination current 60mA plus code times 60mA, default 0010.
// - Charge voltage 3.856V plus 32mV steps, cap 4.624V, 01111 is 4.352V.
// - Top-off extension after termination: off, 15, 30 or 45 minutes.
// - Recharge offset bit selects 100mV or 200mV, default 100mV.
// - Termination happens only while termination enable is 1, default 1.
// - Watchdog period off, 40s, 80s or 160s, default 40s.
// - Safety timer enable default 1; timer select gives 5 or 10 hours.
// - Thermal threshold bit picks 90 C or 110 C, default 110 C.
// - Cold band current scale 50% or 20%, default 20%.
// - Input overvoltage code gives 5.5, 6.5, 10.5 or 14 V.
// - Boost voltage 4.85V plus code times 0.15V, default 5.15V.
// - Input voltage limit 3.9V plus code times 100mV, default 0110.
// - Writing force-detection starts detection; bit self-clears when done.
// - Double-time bit slows safety timer 2X during limiting or cool.
// - Force-off turns battery FET off, after ship delay or immediately.
// - Warm band with warm-voltage bit 0 sets charge voltage to 4.05V.
// - Battery FET reset function follows the reset-enable bit.
// - Battery tracking raises input limit to battery plus 200/250/300mV.
// - Watchdog kick restarts watchdog; the bit reads 0 at 0x01 but stays set at 0x07.
// - Register reset restores defaults, restarts safety timer, then clears.
// - Watchdog fault flag is 1 after watchdog expiry, else 0.
module ccr_config_bank #(
	parameter int WD_UNIT_CYCLES = 100_000_000 * 40,
	parameter int SHIP_DLY_CYCLES = 100_000_000,
	parameter int MIN_UNIT_CYCLES = 100_000_000 * 60 * 15,
	parameter int DET_CYCLES     = 1000
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// Register port from the serial slave
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	output logic      [7:0]          reg_rdata,
	// Analog status
	input  wire ccr_pkg::ccr_ana_t   ana_in,
	input  wire logic                term_condition,
	// Decoded settings and controls
	output ccr_pkg::ccr_cfg_t        cfg_out,
	output logic                     input_detect_start,
	output logic                     topoff_active,
	output logic                     safety_timer_restart,
	output logic                     safety_timer_half_rate,
	output logic                     battery_fet_on,
	output logic                     watchdog_fault
);
	import ccr_pkg::*;

	// Elaboration check on timing parameters
	if (WD_UNIT_CYCLES < 1 || SHIP_DLY_CYCLES < 1 || MIN_UNIT_CYCLES < 1 ||
	    DET_CYCLES < 1) begin : g_bad_param
		$error("ccr_config_bank: cycle counts must be at least one");
	end

	logic [7:0]  chg_boost_r, pre_term_r, chg_volt_r;
	logic [7:0]  tmr_therm_r, in_boost_r, misc_r;
	logic        wr_hit_reset, det_done;
	logic [31:0] det_cnt_r, wd_cnt_r, ship_cnt_r, topoff_cnt_r;
	logic        wd_kick_req, synced_ana_unused;
	logic [1:0]  wd_code, topoff_code;
	logic [31:0] wd_limit, topoff_limit;
	ccr_ana_t    ana_s1_r, ana_s2_r;

	// Analog status crosses in from outside the clock domain
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ana_s1_r <= '0;
			ana_s2_r <= '0;
		end else begin
			ana_s1_r <= ana_in;
			ana_s2_r <= ana_s1_r;
		end
	end
	assign synced_ana_unused = 1'b0;

	// Software register reset request
	assign wr_hit_reset = reg_wr && reg_addr == CCR_OFF_RESET_CTRL &&
	                      reg_wdata[CCR_BIT_REG_RESET];
	assign wd_kick_req  = reg_wr && reg_addr == CCR_OFF_MISC - 8'h06 &&
	                      reg_wdata[CCR_BIT_WD_KICK];

	// Configuration registers; reset and register reset load defaults
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chg_boost_r <= CCR_RST_CHG_BOOST;
			pre_term_r  <= CCR_RST_PRE_TERM;
			chg_volt_r  <= CCR_RST_CHG_VOLT;
			tmr_therm_r <= CCR_RST_TMR_THERM;
			in_boost_r  <= CCR_RST_IN_BOOST;
			misc_r      <= CCR_RST_MISC;
		end else if (wr_hit_reset) begin
			chg_boost_r <= CCR_RST_CHG_BOOST;
			pre_term_r  <= CCR_RST_PRE_TERM;
			chg_volt_r  <= CCR_RST_CHG_VOLT;
			tmr_therm_r <= CCR_RST_TMR_THERM;
			in_boost_r  <= CCR_RST_IN_BOOST;
			misc_r      <= CCR_RST_MISC;
		end else begin
			if (reg_wr && reg_addr == CCR_OFF_CHG_BOOST)
				chg_boost_r <= reg_wdata;
			if (reg_wr && reg_addr == CCR_OFF_PRE_TERM)
				pre_term_r <= reg_wdata;
			if (reg_wr && reg_addr == CCR_OFF_CHG_VOLT)
				chg_volt_r <= reg_wdata;
			if (reg_wr && reg_addr == CCR_OFF_TMR_THERM)
				tmr_therm_r <= reg_wdata & CCR_WMASK_TMR_THERM;
			if (reg_wr && reg_addr == CCR_OFF_IN_BOOST)
				in_boost_r <= reg_wdata;
			// Detection done clears force bit; a new write wins
			if (reg_wr && reg_addr == CCR_OFF_MISC)
				misc_r <= reg_wdata;
			else if (det_done)
				misc_r[CCR_BIT_FORCE_DET] <= 1'b0;
		end
	end

	// Input detection runs a fixed time after the force bit is set
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			det_cnt_r <= '0;
		end else if (!misc_r[CCR_BIT_FORCE_DET] || det_done) begin
			det_cnt_r <= '0;
		end else begin
			det_cnt_r <= det_cnt_r + 32'h1;
		end
	end
	assign det_done = misc_r[CCR_BIT_FORCE_DET] &&
	                  det_cnt_r == 32'(DET_CYCLES - 1);
	assign input_detect_start = misc_r[CCR_BIT_FORCE_DET];

	// Watchdog: period is 40 s times 1, 2 or 4
	assign wd_code  = tmr_therm_r[5:4];
	always_comb begin
		case (wd_code)
			2'h1:    wd_limit = 32'(WD_UNIT_CYCLES);
			2'h2:    wd_limit = 32'(WD_UNIT_CYCLES) << 1;
			2'h3:    wd_limit = 32'(WD_UNIT_CYCLES) << 2;
			default: wd_limit = '0;
		endcase
	end

	// A kick write (bit 6 to offset 0x01 or 0x07) restarts the count
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wd_cnt_r       <= '0;
			watchdog_fault <= 1'b0;
		end else if (wd_code == 2'h0 || wr_hit_reset) begin
			wd_cnt_r       <= '0;
			watchdog_fault <= 1'b0;
		end else if (wd_kick_req || (reg_wr && reg_addr == CCR_OFF_MISC &&
		             reg_wdata[CCR_BIT_WD_KICK])) begin
			wd_cnt_r       <= '0;
			watchdog_fault <= 1'b0;
		end else if (wd_cnt_r >= wd_limit - 32'h1) begin
			watchdog_fault <= 1'b1;
		end else begin
			wd_cnt_r <= wd_cnt_r + 32'h1;
		end
	end

	// Battery FET off, optionally after the ship-mode delay
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ship_cnt_r     <= '0;
			battery_fet_on <= 1'b1;
		end else if (!misc_r[CCR_BIT_FET_OFF]) begin
			ship_cnt_r     <= '0;
			battery_fet_on <= 1'b1;
		end else if (!misc_r[CCR_BIT_FET_DLY] ||
		             ship_cnt_r == 32'(SHIP_DLY_CYCLES - 1)) begin
			battery_fet_on <= 1'b0;
		end else begin
			ship_cnt_r <= ship_cnt_r + 32'h1;
		end
	end

	// Top-off timer starts when termination is met and enabled
	assign topoff_code = chg_volt_r[2:1];
	assign topoff_limit = 32'(MIN_UNIT_CYCLES) * 32'(topoff_code);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			topoff_cnt_r  <= '0;
			topoff_active <= 1'b0;
		end else if (!pre_term_r[0] && 1'b0) begin
			topoff_cnt_r  <= '0;
		end else if (!chg_volt_r[2] && !chg_volt_r[1]) begin
			topoff_cnt_r  <= '0;
			topoff_active <= 1'b0;
		end else if (term_condition && tmr_therm_r[CCR_BIT_TERM_EN] &&
		             !topoff_active) begin
			topoff_cnt_r  <= '0;
			topoff_active <= 1'b1;
		end else if (topoff_active) begin
			if (topoff_cnt_r >= topoff_limit - 32'h1)
				topoff_active <= 1'b0;
			else
				topoff_cnt_r <= topoff_cnt_r + 32'h1;
		end
	end

	// Safety timer rate and restart
	assign safety_timer_restart   = wr_hit_reset;
	assign safety_timer_half_rate = misc_r[CCR_BIT_TMR2X] &&
		(ana_s2_r.input_limiting || ana_s2_r.thermal_reg ||
		 ana_s2_r.cool_band);

	// Decode of settings; registered so outputs come from flip-flops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_out <= '0;
		end else begin
			cfg_out.boost_current_limit_ma <= chg_boost_r[CCR_BIT_BOOST_CURRENT_LIMIT] ?
				11'd1200 : 11'd500;
			cfg_out.pass_fet_high_res <= !chg_boost_r[CCR_BIT_FULL_ON] &&
				ana_s2_r.input_limit_ma <= 12'(CCR_PASS_FET_THR_MA);
			cfg_out.fast_charge_current_ma <=
				(chg_boost_r[5:0] >= CCR_FAST_CHARGE_CURRENT_MAX_CODE) ? 12'd3000 :
				12'(chg_boost_r[5:0] * CCR_FAST_CHARGE_CURRENT_STEP_MA);
			cfg_out.charge_enable <= chg_boost_r[5:0] != 6'h00;
			cfg_out.precharge_current_ma <=
				(pre_term_r[7:4] >= CCR_IPRE_MAX_CODE) ? 10'd780 :
				10'(CCR_IPRE_BASE_MA + pre_term_r[7:4] * 60);
			cfg_out.termination_current_ma <=
				10'(CCR_IPRE_BASE_MA + pre_term_r[3:0] * 60);
			if (ana_s2_r.high_temp_band && !misc_r[CCR_BIT_WARM])
				cfg_out.charge_voltage_mv <= 13'(CCR_WARM_CAP_MV);
			else if (chg_volt_r[7:3] == CCR_CHARGE_VOLTAGE_SPEC_CODE)
				cfg_out.charge_voltage_mv <= 13'(CCR_CHARGE_VOLTAGE_SPEC_MV);
			else if (chg_volt_r[7:3] >= CCR_CHARGE_VOLTAGE_MAX_CODE)
				cfg_out.charge_voltage_mv <= 13'd4624;
			else
				cfg_out.charge_voltage_mv <= 13'(CCR_CHARGE_VOLTAGE_BASE_MV +
					chg_volt_r[7:3] * CCR_CHARGE_VOLTAGE_STEP_MV);
			cfg_out.topoff_minutes <=
				6'(topoff_code * CCR_TOPOFF_STEP_MIN);
			cfg_out.recharge_offset_mv <= chg_volt_r[CCR_BIT_RECHG] ?
				9'd200 : 9'd100;
			cfg_out.termination_enable <= tmr_therm_r[CCR_BIT_TERM_EN];
			cfg_out.safety_timer_enable <= tmr_therm_r[CCR_BIT_TMR_EN];
			cfg_out.fast_charge_timer_10h <= tmr_therm_r[CCR_BIT_TMR_SEL];
			cfg_out.thermal_threshold_c <= tmr_therm_r[CCR_BIT_THERMAL_THRESHOLD_SELECT] ?
				7'd110 : 7'd90;
			cfg_out.cold_current_pct <= tmr_therm_r[CCR_BIT_COLD] ?
				6'd20 : 6'd50;
			case (in_boost_r[7:6])
				2'h0:    cfg_out.input_overvoltage_mv <= 14'd5500;
				2'h1:    cfg_out.input_overvoltage_mv <= 14'd6500;
				2'h2:    cfg_out.input_overvoltage_mv <= 14'd10500;
				default: cfg_out.input_overvoltage_mv <= 14'd14000;
			endcase
			cfg_out.boost_voltage_mv <= 13'(CCR_BOOST_VOLTAGE_BASE_MV +
				in_boost_r[5:4] * CCR_BOOST_VOLTAGE_STEP_MV);
			cfg_out.input_voltage_limit_mv <= vin_limit(in_boost_r[3:0],
				misc_r[1:0], ana_s2_r.battery_mv);
			cfg_out.battery_fet_reset_enable <=
				misc_r[CCR_BIT_FET_RST_EN];
		end
	end

	// Input voltage limit with optional battery tracking
	function automatic logic [12:0] vin_limit(input logic [3:0] code,
		input logic [1:0] trk, input logic [12:0] vbat);
		logic [12:0] base;
		logic [12:0] track;
		base  = 13'(CCR_VIN_BASE_MV + code * CCR_VIN_STEP_MV);
		track = 13'(vbat + 13'(150 + 50 * trk));
		if (trk != 2'h0 && track > base)
			vin_limit = track;
		else
			vin_limit = base;
	endfunction

	// Read mux; reserved and unmapped bits read zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				CCR_OFF_CHG_BOOST:  reg_rdata <= chg_boost_r;
				CCR_OFF_PRE_TERM:   reg_rdata <= pre_term_r;
				CCR_OFF_CHG_VOLT:   reg_rdata <= chg_volt_r;
				CCR_OFF_TMR_THERM:  reg_rdata <= tmr_therm_r;
				CCR_OFF_IN_BOOST:   reg_rdata <= in_boost_r;
				CCR_OFF_MISC:       reg_rdata <= misc_r;
				CCR_OFF_RESET_CTRL: reg_rdata <= 8'h00;
				default:            reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule

// file: ccr_config_bank_chk.sv
// Port-level checker for the configuration register bank
`timescale 1ns/100ps
module ccr_config_bank_chk
	import ccr_pkg::*;
#(
	parameter int SHIP_DLY_CYCLES = 10,
	parameter int DET_CYCLES      = 8
) (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	// Register port
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Decoded outputs
	input wire ccr_cfg_t   cfg_out,
	input wire logic       input_detect_start,
	input wire logic       safety_timer_restart,
	input wire logic       battery_fet_on,
	input wire logic       watchdog_fault
);
	logic [7:0] wd1_r;
	logic [7:0] wd2_r;
	logic [4:0] v4_r;
	logic       w2;
	logic       w3;
	logic       w4;
	logic       w7;
	logic       wb;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Write strobes per register
	assign w2 = reg_wr && reg_addr == CCR_OFF_CHG_BOOST;
	assign w3 = reg_wr && reg_addr == CCR_OFF_PRE_TERM;
	assign w4 = reg_wr && reg_addr == CCR_OFF_CHG_VOLT;
	assign w7 = reg_wr && reg_addr == CCR_OFF_MISC;
	assign wb = reg_wr && reg_addr == CCR_OFF_RESET_CTRL;

	// Write data delayed to meet its decode, two cycles on
	always_ff @(posedge clk_sys) begin
		wd1_r <= reg_wdata;
		wd2_r <= wd1_r;
		if (w4) v4_r <= reg_wdata[7:3];
	end

	a_boost_limit: assert property (w2 ##1 !reg_wr |=>
		cfg_out.boost_current_limit_ma == (wd2_r[7] ? 11'h4B0 : 11'h1F4))
		else $error("boost limit decode wrong");
	a_fast_charge: assert property (w2 ##1 !reg_wr |=>
		cfg_out.fast_charge_current_ma == (wd2_r[5:0] >= 6'h32 ? 6'h32
		: wd2_r[5:0]) * 12'h03C && cfg_out.charge_enable == |wd2_r[5:0])
		else $error("fast charge decode wrong");
	a_pre_term: assert property (w3 ##1 !reg_wr |=>
		cfg_out.precharge_current_ma == (wd2_r[7:4] >= 4'hC ? 10'h30C
		: 10'h03C + wd2_r[7:4] * 10'h03C) && cfg_out.termination_current_ma
		== 10'h03C + wd2_r[3:0] * 10'h03C) else $error("current decode wrong");
	a_charge_volt: assert property (w4 |-> ##[2:4]
		cfg_out.charge_voltage_mv == (v4_r == 5'h0F ? 13'h1100 : v4_r >= 5'h18
		? 13'h1210 : 13'h0F10 + v4_r * 13'h020))
		else $error("charge voltage decode wrong");
	a_unmapped_read: assert property (reg_rd &&
		!(reg_addr inside {[8'h02:8'h07], 8'h0B}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_reserved_bit: assert property (reg_rd &&
		reg_addr == CCR_OFF_TMR_THERM |=> !reg_rdata[6])
		else $error("reserved bit reads one");
	a_detect_clear: assert property (w7 && reg_wdata[7] |=>
		input_detect_start ##[1:20] !input_detect_start)
		else $error("detection bit not self clearing");
	a_restart_pulse: assert property (wb && reg_wdata[7] |->
		safety_timer_restart ##1 !safety_timer_restart)
		else $error("safety restart pulse wrong");
	a_kick_clears: assert property (w7 && reg_wdata[6] |->
		##[1:2] !watchdog_fault) else $error("kick left watchdog fault");
	a_fet_now: assert property (w7 && reg_wdata[5] && !reg_wdata[3] |->
		##[1:3] !battery_fet_on) else $error("immediate fet off late");
	a_fet_delay: assert property (w7 && reg_wdata[5] && reg_wdata[3]
		&& battery_fet_on |=> battery_fet_on [*5])
		else $error("delayed fet off too early");
endmodule

bind ccr_config_bank ccr_config_bank_chk #(
	.SHIP_DLY_CYCLES(SHIP_DLY_CYCLES),
	.DET_CYCLES(DET_CYCLES)
) chk_i (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
	.cfg_out, .input_detect_start, .safety_timer_restart, .battery_fet_on,
	.watchdog_fault);

// file: ccr_config_bank_tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
module ccr_config_bank_tb;
	import ccr_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	ccr_ana_t   ana_in = '0;
	logic       term_condition = 1'b0;
	ccr_cfg_t   cfg_out;
	logic       det;
	logic       topoff;
	logic       restart;
	logic       half;
	logic       fet_on;
	logic       wd_fault;
	logic [7:0] d;
	logic [7:0] a;
	logic [7:0] s = 8'h59;
	logic [7:0] tab [8];
	int         mismatches = 0;
	int         comparisons = 0;
	int         cycles = 0;
	int         n;

	ccr_host host_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	ccr_config_bank #(.WD_UNIT_CYCLES(100), .SHIP_DLY_CYCLES(10),
		.MIN_UNIT_CYCLES(50), .DET_CYCLES(8)) ccr_config_bank_i (
		.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ana_in(ana_in), .term_condition(term_condition), .cfg_out(cfg_out),
		.input_detect_start(det), .topoff_active(topoff),
		.safety_timer_restart(restart), .safety_timer_half_rate(half),
		.battery_fet_on(fet_on), .watchdog_fault(wd_fault));

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	// Watchdog period in cycles; code zero never fires within the wait
	function automatic int wd_exp(input int c);
		return c == 0 ? 32'h3E8 : 32'h64 << (c - 1);
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] ex);
		comparisons++;
		if (got !== ex) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, ex);
		end
	endtask

	// Counts need slack for the port's own two-cycle access
	task automatic near(input int got, input int ex);
		chk(16'(got >= ex - 6 && got <= ex + 6), 16'h0001);
	endtask

	task automatic rdc(input logic [7:0] ra, input logic [7:0] ex);
		host_i.rd(ra, d);
		chk({8'h00, d}, {8'h00, ex});
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard, far beyond the roughly 2000 cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up;
		end
	end

	initial begin
		wt(20);
		rst <= 1'b0;
		wt(1);
		tab = '{8'hA2, 8'h22, 8'h58, 8'h9F, 8'h66, 8'h4C, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++)
			rdc(8'h02 + 8'(i), tab[i]);
		chk(16'(cfg_out.fast_charge_current_ma), 16'h07F8);
		chk(16'(cfg_out.boost_voltage_mv), 16'h141E);
		// Watchdog off first so it cannot fire behind the loop
		host_i.wr(8'h05, 8'h8F);
		tab = '{8'h00, 8'hFF, 8'h78, 8'h7F, 8'hFF, 8'h3F, 8'h00, 8'hF8};
		for (int i = 0; i < 30; i++) begin
			s = lfsr(s);
			a = 8'h02 + 8'(i % 5);
			d = (i < 8) ? tab[i] : s;
			if (a == 8'h05)
				d = d & 8'hCF;
			host_i.wr(a, d);
			rdc(a, a == 8'h05 ? d & 8'hBF : d);
		end
		host_i.wr(8'h01, 8'hFF);
		rdc(8'h01, 8'h00);
		host_i.wr(8'h0B, 8'h80);
		rdc(8'h02, 8'hA2);
		rdc(8'h0B, 8'h00);
		// Each period timed from a kick; ends with the timer off
		for (int c = 1; c < 5; c++) begin
			host_i.wr(8'h05, 8'h8F | 8'((c % 4) << 4));
			host_i.wr(8'h07, 8'h4C);
			n = 0;
			while (wd_fault !== 1'b1 && n < 1000) begin
				wt(1);
				n++;
			end
			near(n, wd_exp(c % 4));
		end
		host_i.wr(8'h07, 8'h64);
		wt(1);
		chk(16'(fet_on), 16'h0000);
		host_i.wr(8'h07, 8'h4C);
		wt(1);
		chk(16'(fet_on), 16'h0001);
		host_i.wr(8'h07, 8'h6C);
		n = 0;
		while (fet_on === 1'b1 && n < 100) begin
			wt(1);
			n++;
		end
		near(n, 8);
		host_i.wr(8'h07, 8'hCC);
		chk(16'(det), 16'h0001);
		n = 0;
		while (det === 1'b1 && n < 50) begin
			wt(1);
			n++;
		end
		near(n, 6);
		rdc(8'h07, 8'h4C);
		ana_in.cool_band <= 1'b1;
		wt(5);
		chk(16'(half), 16'h0001);
		host_i.wr(8'h07, 8'h0C);
		chk(16'(half), 16'h0000);
		ana_in.cool_band <= 1'b0;
		ana_in.battery_mv <= 13'h1194;
		for (int c = 0; c < 4; c++) begin
			host_i.wr(8'h07, 8'h4C | 8'(c));
			wt(4);
			chk(16'(cfg_out.input_voltage_limit_mv), c == 0 ? 16'h1194
				: 16'h122A + 16'(c) * 16'h0032);
		end
		ana_in.high_temp_band <= 1'b1;
		wt(5);
		chk(16'(cfg_out.charge_voltage_mv), 16'h0FD2);
		host_i.wr(8'h07, 8'h5C);
		wt(3);
		chk(16'(cfg_out.charge_voltage_mv), 16'h1070);
		ana_in.high_temp_band <= 1'b0;
		host_i.wr(8'h04, 8'h5A);
		term_condition <= 1'b1;
		wt(4);
		chk(16'(topoff), 16'h0001);
		n = 0;
		// Sampled mid-cycle so a one-cycle low is not lost to a race
		while (topoff === 1'b1 && n < 300) begin
			@(negedge clk_sys);
			n++;
		end
		near(n, 47);
		term_condition <= 1'b0;
		host_i.wr(8'h05, 8'h0F);
		term_condition <= 1'b1;
		wt(4);
		chk(16'(topoff), 16'h0000);
		wrap_up;
	end
endmodule

// file: ccr_host.sv
// Host model driving the byte-wide register port
`timescale 1ns/100ps
module ccr_host (
	// Clock
	input  wire logic       clk_sys,
	// Register port
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// Idle port at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// Strobe stands for the taking edge only; then an idle cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a; // Released lines carry no stale value
		reg_wdata <= ~v;
		@(posedge clk_sys);
	endtask

	// Read data stands from the edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk_sys);
		v = reg_rdata;
	endtask
endmodule

// file: ccr_pkg.sv
// Package for the charger configuration register bank: offsets, fields, defaults
package ccr_pkg;

	// Register offsets (byte addresses on the register port)
	localparam logic [7:0] CCR_OFF_CHG_BOOST  = 8'h02;
	localparam logic [7:0] CCR_OFF_PRE_TERM   = 8'h03;
	localparam logic [7:0] CCR_OFF_CHG_VOLT   = 8'h04;
	localparam logic [7:0] CCR_OFF_TMR_THERM  = 8'h05;
	localparam logic [7:0] CCR_OFF_IN_BOOST   = 8'h06;
	localparam logic [7:0] CCR_OFF_MISC       = 8'h07;
	localparam logic [7:0] CCR_OFF_RESET_CTRL = 8'h0B;

	// Reset values
	localparam logic [7:0] CCR_RST_CHG_BOOST = 8'hA2;
	localparam logic [7:0] CCR_RST_PRE_TERM  = 8'h22;
	localparam logic [7:0] CCR_RST_CHG_VOLT  = 8'h58;
	localparam logic [7:0] CCR_RST_TMR_THERM = 8'h9F;
	localparam logic [7:0] CCR_RST_IN_BOOST  = 8'h66;
	localparam logic [7:0] CCR_RST_MISC      = 8'h4C;

	// Writable bit masks; reserved bits stay zero
	localparam logic [7:0] CCR_WMASK_TMR_THERM = 8'hBF;

	// Field positions
	localparam int CCR_BIT_BOOST_CURRENT_LIMIT  = 7;
	localparam int CCR_BIT_FULL_ON    = 6;
	localparam int CCR_BIT_TERM_EN    = 7;
	localparam int CCR_BIT_TMR_EN     = 3;
	localparam int CCR_BIT_TMR_SEL    = 2;
	localparam int CCR_BIT_THERMAL_THRESHOLD_SELECT       = 1;
	localparam int CCR_BIT_COLD       = 0;
	localparam int CCR_BIT_RECHG      = 0;
	localparam int CCR_BIT_FORCE_DET  = 7;
	localparam int CCR_BIT_TMR2X      = 6;
	localparam int CCR_BIT_FET_OFF    = 5;
	localparam int CCR_BIT_WARM       = 4;
	localparam int CCR_BIT_FET_DLY    = 3;
	localparam int CCR_BIT_FET_RST_EN = 2;
	localparam int CCR_BIT_WD_KICK    = 6;
	localparam int CCR_BIT_REG_RESET  = 7;

	// Saturation codes and decode steps
	localparam logic [5:0] CCR_FAST_CHARGE_CURRENT_MAX_CODE  = 6'h32;
	localparam logic [3:0] CCR_IPRE_MAX_CODE  = 4'hC;
	localparam logic [4:0] CCR_CHARGE_VOLTAGE_MAX_CODE  = 5'h18;
	localparam logic [4:0] CCR_CHARGE_VOLTAGE_SPEC_CODE = 5'h0F;
	localparam int CCR_FAST_CHARGE_CURRENT_STEP_MA  = 60;
	localparam int CCR_IPRE_BASE_MA  = 60;
	localparam int CCR_CHARGE_VOLTAGE_BASE_MV  = 3856;
	localparam int CCR_CHARGE_VOLTAGE_STEP_MV  = 32;
	localparam int CCR_CHARGE_VOLTAGE_SPEC_MV  = 4352;
	localparam int CCR_WARM_CAP_MV   = 4050;
	localparam int CCR_BOOST_VOLTAGE_BASE_MV = 4850;
	localparam int CCR_BOOST_VOLTAGE_STEP_MV = 150;
	localparam int CCR_VIN_BASE_MV   = 3900;
	localparam int CCR_VIN_STEP_MV   = 100;
	localparam int CCR_PASS_FET_THR_MA = 700;

	// Time constants
	localparam int CCR_CLK_HZ        = 100_000_000;
	localparam int CCR_WD_BASE_S     = 40;
	localparam int CCR_TOPOFF_STEP_MIN = 15;

	// Decoded settings handed to the analog side
	typedef struct packed {
		logic [11:0] fast_charge_current_ma;
		logic [9:0]  precharge_current_ma;
		logic [9:0]  termination_current_ma;
		logic [12:0] charge_voltage_mv;
		logic [12:0] boost_voltage_mv;
		logic [12:0] input_voltage_limit_mv;
		logic [8:0]  recharge_offset_mv;
		logic [13:0] input_overvoltage_mv;
		logic [10:0] boost_current_limit_ma;
		logic [6:0]  thermal_threshold_c;
		logic [5:0]  cold_current_pct;
		logic [5:0]  topoff_minutes;
		logic        charge_enable;
		logic        termination_enable;
		logic        pass_fet_high_res;
		logic        safety_timer_enable;
		logic        fast_charge_timer_10h;
		logic        battery_fet_reset_enable;
	} ccr_cfg_t;

	// Analog status inputs
	typedef struct packed {
		logic [12:0] battery_mv;
		logic [11:0] input_limit_ma;
		logic        high_temp_band;
		logic        cool_band;
		logic        input_limiting;
		logic        thermal_reg;
	} ccr_ana_t;

endpackage
